/* rtl/bvs_consts.vh */
/*
 boot vector select constants: register offsets, reset values, addresses.
 assumes plain verilog-2005, included by bare name.
*/
`ifndef BVS_CONSTS_VH
`define BVS_CONSTS_VH
`define BVS_USER_START 16'h0000
`define BVS_LOW_BYTE 8'h00
`define BVS_VECTOR_DEFAULT 8'h1f
`define BVS_ENTRY_ADDR 16'hff03
`define BVS_SECTOR_SHIFT 10
`define BVS_SECTOR_MSB 12
`define BVS_OFF_CTRL 8'h00
`define BVS_OFF_STATUS 8'h04
`define BVS_OFF_BOOT 8'h08
`define BVS_OFF_CFG 8'h0c
`define BVS_OFF_SEC_LO 8'h10
`define BVS_OFF_SEC_HI 8'h14
`define BVS_OFF_FCS 8'h18
`define BVS_OFF_FDATA 8'h1c
`define BVS_OFF_FADRL 8'h20
`define BVS_OFF_FADRH 8'h24
`define BVS_OFF_ENTRY 8'h28
`define BVS_ST_START 1'b0
`define BVS_ST_BUSY 1'b1
`define BVS_FCS_GO 0
`define BVS_FCS_ERASE 1
`define BVS_FCS_BLOCKED 6
`define BVS_FCS_BUSY 7
`define BVS_FLASH_OP_CYCLES 8'h20
`define BVS_RESP_OKAY 2'b00
`define BVS_RESP_SLVERR 2'b10
`endif

/* rtl/bvs_top.v */
/*
 boot vector select: after reset picks the first fetch address from the
 boot status flag, boot vector and the forced-loader strap; latches user
 configuration and sector security bytes once; offers an application
 self-programming register set over axi4-lite.
 assumes non-volatile values arrive as stable levels on the system clock
 domain pins, a strap on an asynchronous pin, and a single 20 MHz clock.
*/
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "bvs_consts.vh"
module bvs_top (
	input wire i_clock,
	input wire i_arst_n,
	input wire i_boot_status_nz,
	input wire [7:0] i_boot_vector,
	input wire i_force_loader,
	input wire [7:0] i_user_config_byte_one,
	input wire [7:0] i_user_config_byte_two,
	input wire [63:0] i_sector_security,
	input wire i_flash_brownout_detector,
	input wire i_code_read_req,
	input wire [15:0] i_code_read_addr,
	input wire [7:0] i_code_read_data,
	input wire [7:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output reg o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output reg o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [7:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output reg o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready,
	output reg o_fetch_valid,
	output reg [15:0] o_fetch_addr,
	output reg o_loader_mode,
	output reg [7:0] o_code_read_data,
	output reg o_code_read_denied,
	output reg o_flash_go,
	output reg o_flash_erase,
	output reg [15:0] o_flash_addr,
	output reg [7:0] o_flash_data
);
	// strap synchroniser is held clear in reset, so the decision waits two
	// edges for it to fill before the forced-loader level is trusted
	localparam ST_START = 4'b0001;
	localparam ST_FILL = 4'b0010;
	localparam ST_DECIDE = 4'b0100;
	localparam ST_RUN = 4'b1000;

	reg force_s1_q, force_s2_q, bod_s1_q, bod_s2_q;
	reg [3:0] state_q;
	reg [7:0] cfg1_q, cfg2_q;
	reg [63:0] sec_q;
	reg [7:0] fcs_q, fdata_q, fadrl_q, fadrh_q;
	reg [7:0] op_cnt_q;
	reg aw_q, w_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [31:0] rd_d;
	reg rd_ok_d;
	wire [2:0] rd_sector = i_code_read_addr[`BVS_SECTOR_MSB:`BVS_SECTOR_SHIFT];
	wire [7:0] rd_sec_byte = sec_q[{rd_sector, 3'b000} +: 8];
	wire wr_fire = aw_q && w_q && !o_s_axi_bvalid;

	// level strap and brownout pass two flops before use
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			force_s1_q <= 1'b0;
			force_s2_q <= 1'b0;
			bod_s1_q <= 1'b0;
			bod_s2_q <= 1'b0;
		end else begin
			force_s1_q <= i_force_loader;
			force_s2_q <= force_s1_q;
			bod_s1_q <= i_flash_brownout_detector;
			bod_s2_q <= bod_s1_q;
		end
	end

	// boot decision, taken once after release, held until next reset
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= ST_START;
			o_fetch_valid <= 1'b0;
			o_fetch_addr <= `BVS_USER_START;
			o_loader_mode <= 1'b0;
			cfg1_q <= 8'h00;
			cfg2_q <= 8'h00;
			sec_q <= 64'h0;
		end else begin
			case (state_q)
				ST_START: begin
					// first synchroniser stage takes the strap
					state_q <= ST_FILL;
				end
				ST_FILL: begin
					// second stage takes the strap
					state_q <= ST_DECIDE;
				end
				ST_DECIDE: begin
					state_q <= ST_RUN;
					o_fetch_valid <= 1'b1;
					cfg1_q <= i_user_config_byte_one;
					cfg2_q <= i_user_config_byte_two;
					sec_q <= i_sector_security;
					if (i_boot_status_nz || force_s2_q) begin
						o_loader_mode <= 1'b1;
						o_fetch_addr <= {i_boot_vector, `BVS_LOW_BYTE};
					end else begin
						o_loader_mode <= 1'b0;
						o_fetch_addr <= `BVS_USER_START;
					end
				end
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_START;
			endcase
		end
	end

	// code memory read gate
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_code_read_data <= 8'h00;
			o_code_read_denied <= 1'b0;
		end else if (i_code_read_req) begin
			o_code_read_denied <= (rd_sec_byte != 8'h00);
			o_code_read_data <= (rd_sec_byte != 8'h00) ? 8'h00 : i_code_read_data;
		end
	end

	// self-programming registers and flash operation
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `BVS_RESP_OKAY;
			fcs_q <= 8'h00;
			fdata_q <= 8'h00;
			fadrl_q <= 8'h00;
			fadrh_q <= 8'h00;
			op_cnt_q <= 8'h00;
			o_flash_go <= 1'b0;
			o_flash_erase <= 1'b0;
			o_flash_addr <= 16'h0000;
			o_flash_data <= 8'h00;
		end else begin
			o_flash_go <= 1'b0;
			o_s_axi_awready <= !aw_q && !o_s_axi_awready && i_s_axi_awvalid;
			o_s_axi_wready <= !w_q && !o_s_axi_wready && i_s_axi_wvalid;
			if (o_s_axi_awready && i_s_axi_awvalid) begin
				aw_q <= 1'b1;
				awaddr_q <= i_s_axi_awaddr;
			end
			if (o_s_axi_wready && i_s_axi_wvalid) begin
				w_q <= 1'b1;
				wdata_q <= i_s_axi_wdata;
				wstrb_q <= i_s_axi_wstrb;
			end
			if (op_cnt_q != 8'h00) begin
				op_cnt_q <= op_cnt_q - 8'h01;
				if (op_cnt_q == 8'h01)
					fcs_q[`BVS_FCS_BUSY] <= 1'b0;
			end
			if (bod_s2_q)
				fcs_q[`BVS_FCS_BLOCKED] <= 1'b1;
			if (wr_fire) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= `BVS_RESP_OKAY;
				case (awaddr_q)
					`BVS_OFF_FDATA: if (wstrb_q[0]) fdata_q <= wdata_q[7:0];
					`BVS_OFF_FADRL: if (wstrb_q[0]) fadrl_q <= wdata_q[7:0];
					`BVS_OFF_FADRH: if (wstrb_q[0]) fadrh_q <= wdata_q[7:0];
					`BVS_OFF_FCS: if (wstrb_q[0]) begin
						fcs_q[`BVS_FCS_ERASE] <= wdata_q[`BVS_FCS_ERASE];
						// blocked flag clears by writing one, unless brownout still present
						if (wdata_q[`BVS_FCS_BLOCKED] && !bod_s2_q)
							fcs_q[`BVS_FCS_BLOCKED] <= 1'b0;
						if (wdata_q[`BVS_FCS_GO] && op_cnt_q == 8'h00) begin
							if (bod_s2_q) begin
								fcs_q[`BVS_FCS_BLOCKED] <= 1'b1;
							end else begin
								o_flash_go <= 1'b1;
								o_flash_erase <= wdata_q[`BVS_FCS_ERASE];
								o_flash_addr <= {fadrh_q, fadrl_q};
								o_flash_data <= fdata_q;
								fcs_q[`BVS_FCS_BUSY] <= 1'b1;
								op_cnt_q <= `BVS_FLASH_OP_CYCLES;
							end
						end
					end
					`BVS_OFF_CTRL, `BVS_OFF_STATUS, `BVS_OFF_BOOT, `BVS_OFF_CFG,
					`BVS_OFF_SEC_LO, `BVS_OFF_SEC_HI, `BVS_OFF_ENTRY: ; // read-only, cfg frozen
					default: o_s_axi_bresp <= `BVS_RESP_SLVERR;
				endcase
			end
			if (o_s_axi_bvalid && i_s_axi_bready)
				o_s_axi_bvalid <= 1'b0;
		end
	end

	always @* begin
		rd_ok_d = 1'b1;
		case (i_s_axi_araddr)
			`BVS_OFF_CTRL: rd_d = {31'h0, o_loader_mode};
			`BVS_OFF_STATUS: rd_d = {30'h0, bod_s2_q, o_fetch_valid};
			`BVS_OFF_BOOT: rd_d = {16'h0, o_fetch_addr};
			`BVS_OFF_CFG: rd_d = {16'h0, cfg2_q, cfg1_q};
			`BVS_OFF_SEC_LO: rd_d = sec_q[31:0];
			`BVS_OFF_SEC_HI: rd_d = sec_q[63:32];
			`BVS_OFF_FCS: rd_d = {24'h0, fcs_q};
			`BVS_OFF_FDATA: rd_d = {24'h0, fdata_q};
			`BVS_OFF_FADRL: rd_d = {24'h0, fadrl_q};
			`BVS_OFF_FADRH: rd_d = {24'h0, fadrh_q};
			`BVS_OFF_ENTRY: rd_d = {16'h0, `BVS_ENTRY_ADDR};
			default: begin
				rd_d = 32'h0;
				rd_ok_d = 1'b0;
			end
		endcase
	end

	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0;
			o_s_axi_rresp <= `BVS_RESP_OKAY;
		end else begin
			o_s_axi_arready <= !o_s_axi_rvalid && !o_s_axi_arready && i_s_axi_arvalid;
			if (o_s_axi_arready && i_s_axi_arvalid) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata <= rd_d;
				o_s_axi_rresp <= rd_ok_d ? `BVS_RESP_OKAY : `BVS_RESP_SLVERR;
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* verification/bvs_top_asserts.sv */
/*
 checker for bvs_top: boot address pick, code read guard, flash go.
 assumes a bind onto bvs_top and one clock domain.
*/
module bvs_top_asserts (
	input wire i_clock,
	input wire i_arst_n,
	input wire i_boot_status_nz,
	input wire [7:0] i_boot_vector,
	input wire i_force_loader,
	input wire [63:0] i_sector_security,
	input wire i_flash_brownout_detector,
	input wire i_code_read_req,
	input wire [15:0] i_code_read_addr,
	input wire [7:0] i_code_read_data,
	input wire o_fetch_valid,
	input wire [15:0] o_fetch_addr,
	input wire o_loader_mode,
	input wire [7:0] o_code_read_data,
	input wire o_code_read_denied,
	input wire o_flash_go
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	wire secured = |i_sector_security[{i_code_read_addr[12:10], 3'h0} +: 8];
	sequence s_low_supply;
		i_flash_brownout_detector [*6];
	endsequence
	sequence s_secured_read;
		i_code_read_req && secured;
	endsequence
	AST_USER_START: assert property ($rose(o_fetch_valid) && !o_loader_mode |-> o_fetch_addr == 16'h0000)
		else $error("user start wrong");
	AST_LOADER_START: assert property (o_fetch_valid && o_loader_mode |-> o_fetch_addr == {i_boot_vector, 8'h00})
		else $error("loader start wrong");
	AST_MODE_PICK: assert property ($rose(o_fetch_valid) |-> o_loader_mode == (i_boot_status_nz | i_force_loader))
		else $error("boot mode wrong");
	AST_HELD: assert property (o_fetch_valid |=> o_fetch_valid && $stable(o_fetch_addr))
		else $error("boot address moved");
	AST_DENY: assert property (s_secured_read |=> o_code_read_denied && o_code_read_data == 8'h00)
		else $error("secured byte leaked");
	AST_OPEN: assert property (i_code_read_req && !secured |=> !o_code_read_denied
		&& o_code_read_data == $past(i_code_read_data))
		else $error("open read wrong");
	AST_BLOCK: assert property (s_low_supply |-> !o_flash_go)
		else $error("flash op in brownout");
	AST_GO_PULSE: assert property (o_flash_go |=> !o_flash_go [*8])
		else $error("go not a pulse");
endmodule

/* verification/bvs_flash_model.sv */
/*
 far-side flash array model: one code byte per address.
 assumes the bench holds the address through each read.
*/
module bvs_flash_model (
	input wire [15:0] i_addr,
	output logic [7:0] o_data
);
	// pattern differs per address so a stale byte shows
	assign o_data = i_addr[7:0] ^ i_addr[15:8] ^ 8'h3c;
endmodule

/* verification/test_bvs_top.sv */
/*
 bench for bvs_top: boot cases, config freeze, code read guard, flash regs.
 assumes bvs_flash_model and the checker beside it.
*/
module test_bvs_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = '0, i_arst_n = '0, i_boot_status_nz = '0, i_force_loader = '0;
	logic i_flash_brownout_detector = '0, i_code_read_req = '0, i_s_axi_awvalid = '0;
	logic i_s_axi_wvalid = '0, i_s_axi_bready = '0, i_s_axi_arvalid = '0, i_s_axi_rready = '0;
	logic [7:0] i_boot_vector = 8'h1f, i_user_config_byte_one = 8'h5a, i_user_config_byte_two = 8'ha5;
	logic [7:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0, go_data;
	logic go_erase;
	logic [15:0] i_code_read_addr = '0, go_addr;
	logic [31:0] i_s_axi_wdata = '0, rdat;
	logic [1:0] rsp;
	wire [7:0] i_code_read_data, o_code_read_data, o_flash_data;
	wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	wire o_fetch_valid, o_loader_mode, o_code_read_denied, o_flash_go, o_flash_erase;
	wire [1:0] o_s_axi_rresp, o_s_axi_bresp;
	wire [31:0] o_s_axi_rdata;
	wire [15:0] o_fetch_addr, o_flash_addr;
	int error_cnt = 0, total_checks = 0, go_cnt = 0, n;
	always #25 i_clock = ~i_clock;
	always @(posedge i_clock) if (o_flash_go) begin
		go_cnt++;
		go_addr = o_flash_addr;
		go_data = o_flash_data;
		go_erase = o_flash_erase;
	end
	bvs_flash_model u_bvs_flash_model (.i_addr(i_code_read_addr), .o_data(i_code_read_data));
	bvs_top u_bvs_top (.*, .i_sector_security(64'h0000_0000_0000_ff00), .i_s_axi_wstrb(4'hf));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic limit();
		if (n >= 50) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		i_s_axi_bready <= 1'h1;
		for (n = 0; n < 50 && !o_s_axi_bvalid; n++) begin
			@(posedge i_clock);
			if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
			if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
		end
		rsp = o_s_axi_bresp;
		i_s_axi_bready <= 1'h0;
		limit();
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready <= 1'h1;
		for (n = 0; n < 50 && !o_s_axi_rvalid; n++) begin
			@(posedge i_clock);
			if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
		end
		rdat = o_s_axi_rdata;
		rsp = o_s_axi_rresp;
		i_s_axi_rready <= 1'h0;
		limit();
	endtask
	task automatic code_rd(input logic [15:0] a, input logic [7:0] d, input logic dn);
		@(posedge i_clock);
		i_code_read_addr <= a;
		i_code_read_req <= 1'h1;
		@(posedge i_clock);
		i_code_read_req <= 1'h0;
		@(posedge i_clock);
		chk("code data", o_code_read_data, d);
		chk("code deny", o_code_read_denied, dn);
	endtask
	task automatic boot(input logic z, f, input logic [7:0] v, input logic [15:0] e);
		@(posedge i_clock);
		i_arst_n <= 1'h0;
		i_boot_status_nz <= z;
		i_force_loader <= f;
		i_boot_vector <= v;
		repeat (6) @(posedge i_clock);
		i_arst_n <= 1'h1;
		repeat (4) @(posedge i_clock);
		chk("fetch addr", o_fetch_addr, e);
		chk("loader mode", o_loader_mode, z | f);
		rd(8'h08);
		chk("boot reg", rdat, e);
	endtask
	initial begin
		boot(1'h0, 1'h0, 8'h1f, 16'h0000);
		boot(1'h1, 1'h0, 8'h1f, 16'h1f00);
		boot(1'h0, 1'h1, 8'h2a, 16'h2a00);
		i_user_config_byte_one <= 8'h00;
		i_user_config_byte_two <= 8'h00;
		wr(8'h0c, 32'h0);
		rd(8'h0c);
		chk("config", rdat, 32'h0000a55a);
		rd(8'h10);
		chk("security lo", rdat, 32'h0000ff00);
		rd(8'h28);
		chk("entry", rdat, 32'h0000ff03);
		wr(8'h40, 32'h0);
		chk("unmapped wr", rsp, 2'h2);
		rd(8'h40);
		chk("unmapped", rsp, 2'h2);
		code_rd(16'h0410, 8'h00, 1'h1);
		code_rd(16'h1f05, 8'h26, 1'h0);
		wr(8'h1c, 32'h77);
		wr(8'h20, 32'h34);
		wr(8'h24, 32'h12);
		wr(8'h18, 32'h1);
		chk("fcs wr", rsp, 2'h0);
		rd(8'h18);
		chk("busy", rdat[7], 1'h1);
		repeat (40) @(posedge i_clock);
		chk("go count", go_cnt, 1);
		chk("go addr", go_addr, 16'h1234);
		chk("go data", go_data, 8'h77);
		chk("go erase", go_erase, 1'h0);
		i_flash_brownout_detector <= 1'h1;
		repeat (8) @(posedge i_clock);
		wr(8'h18, 32'h1);
		repeat (40) @(posedge i_clock);
		chk("blocked go", go_cnt, 1);
		rd(8'h18);
		chk("blocked flag", rdat[6], 1'h1);
		i_force_loader <= 1'h0;
		boot(1'h0, 1'h0, 8'h1f, 16'h0000);
		conclude();
	end
endmodule
bind bvs_top bvs_top_asserts u_bvs_top_asserts (.*);
